// File: rtl/spt_pkg.sv
/*
  constants of the sixteen-bit period timer: register indices and byte addresses,
  control field positions, reset values, prescale codes and bus answer codes.
  assumes nothing of its surroundings; every design file imports it.
*/
package spt_pkg;

  // bus geometry
  localparam int          ADDR_W      = 12;            // byte address width
  localparam int          DATA_W      = 32;            // bus data width
  localparam int          REG_W       = 16;            // register width

  // register indices as printed, plus the interrupt block
  localparam logic [11:0] IDX_COUNT   = 12'h100;       // count_value
  localparam logic [11:0] IDX_PERIOD  = 12'h102;       // period_value
  localparam logic [11:0] IDX_CTRL    = 12'h104;       // timer_control_register
  localparam logic [11:0] IDX_STATUS  = 12'h106;       // sticky event status, read only
  localparam logic [11:0] IDX_CLEAR   = 12'h108;       // write one to clear, write only
  localparam logic [11:0] IDX_ENABLE  = 12'h10A;       // interrupt enables

  // byte addresses: four times the index
  localparam logic [ADDR_W-1:0] ADDR_COUNT  = 12'(IDX_COUNT  * 4);
  localparam logic [ADDR_W-1:0] ADDR_PERIOD = 12'(IDX_PERIOD * 4);
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 12'(IDX_CTRL   * 4);
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'(IDX_STATUS * 4);
  localparam logic [ADDR_W-1:0] ADDR_CLEAR  = 12'(IDX_CLEAR  * 4);
  localparam logic [ADDR_W-1:0] ADDR_ENABLE = 12'(IDX_ENABLE * 4);

  // control field positions
  localparam int          BIT_ON      = 15;            // timer_on_bit
  localparam int          BIT_IDLE    = 13;            // idle_stop_bit
  localparam int          BIT_GATE    = 6;             // gate_accumulate_enable
  localparam int          BIT_PS_HI   = 5;             // prescale_select msb
  localparam int          BIT_PS_LO   = 4;             // prescale_select lsb
  localparam int          BIT_SYNC    = 2;             // external_sync_select
  localparam int          BIT_CS      = 1;             // clock_source_select
  localparam logic [15:0] CTRL_MASK   = 16'hA076;      // implemented control bits

  // status and enable bit positions
  localparam int          EV_MATCH    = 0;             // period match event
  localparam int          EV_GATE     = 1;             // gate falling edge event
  localparam int          EV_N        = 2;             // number of events
  localparam logic [15:0] EV_MASK     = 16'h0003;      // implemented event bits

  // reset values
  localparam logic [15:0] RST_COUNT   = 16'h0000;
  localparam logic [15:0] RST_PERIOD  = 16'hFFFF;
  localparam logic [15:0] RST_CTRL    = 16'h0000;
  localparam logic [1:0]  RST_EV      = 2'h0;

  // prescale codes and their terminal counts
  typedef enum logic [1:0] {
    SPT_PS_1   = 2'h0,
    SPT_PS_8   = 2'h1,
    SPT_PS_64  = 2'h2,
    SPT_PS_256 = 2'h3
  } spt_ps_e;
  localparam logic [7:0]  TERM_8      = 8'h07;
  localparam logic [7:0]  TERM_64     = 8'h3F;
  localparam logic [7:0]  TERM_256    = 8'hFF;

  // bus answers
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage

// File: rtl/spt_link_if.sv
/*
  internal carrier between the timer core, its pin synchroniser and its prescaler.
  assumes all three parties run on the same clock.
*/
`timescale 1ns/10ps
interface spt_link_if;
  import spt_pkg::*;

  logic    pin_level;   // filtered pin level
  logic    pin_rise;    // one-cycle pulse on a filtered rising edge
  logic    pin_fall;    // one-cycle pulse on a filtered falling edge
  logic    tick_in;     // count-source event into the prescaler
  logic    ps_clear;    // prescaler counter clear
  spt_ps_e ps_sel;      // prescale ratio
  logic    tick_out;    // divided count event

  modport sync (output pin_level, output pin_rise, output pin_fall);
  modport pre  (input tick_in, input ps_clear, input ps_sel, output tick_out);
  modport core (input pin_level, input pin_rise, input pin_fall,
                output tick_in, output ps_clear, output ps_sel, input tick_out);
endinterface

// File: rtl/spt_pin_sync.sv
/*
  three-stage synchroniser and edge finder for the external clock or gate pin.
  assumes the pin is asynchronous to aclk and slower than a quarter of its rate.
*/
`timescale 1ns/10ps
module spt_pin_sync (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic pin_raw,
  spt_link_if.sync  lnk
);
  import spt_pkg::*;

  logic s1;     // first stage, read only by s2
  logic s2;     // second stage
  logic s3;     // third stage
  logic lvl;    // accepted level

  // a change counts once the second and third stages agree
  wire agree    = (s2 == s3);
  wire go_high  = agree & s3 & ~lvl;
  wire go_low   = agree & ~s3 & lvl;

  // shift chain and accepted level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1  <= 1'b0;
      s2  <= 1'b0;
      s3  <= 1'b0;
      lvl <= 1'b0;
    end else begin
      s1  <= pin_raw;
      s2  <= s1;
      s3  <= s2;
      if (agree) begin
        lvl <= s3;
      end
    end
  end

  // edge pulses come from flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lnk.pin_rise <= 1'b0;
      lnk.pin_fall <= 1'b0;
    end else begin
      lnk.pin_rise <= go_high;
      lnk.pin_fall <= go_low;
    end
  end

  assign lnk.pin_level = lvl;
endmodule

// File: rtl/spt_prescaler.sv
/*
  count-event prescaler dividing by 1, 8, 64 or 256.
  assumes tick_in is a one-cycle event and only arrives while the timer runs.
*/
`timescale 1ns/10ps
module spt_prescaler (
  input  wire logic aclk,
  input  wire logic aresetn,
  spt_link_if.pre   lnk
);
  import spt_pkg::*;

  logic [7:0] cnt;    // prescaler counter
  logic [7:0] term;   // terminal count of the chosen ratio

  // ratio decode
  always_comb begin
    unique case (lnk.ps_sel)
      SPT_PS_1:   term = 8'h00;
      SPT_PS_8:   term = TERM_8;
      SPT_PS_64:  term = TERM_64;
      SPT_PS_256: term = TERM_256;
    endcase
  end

  wire at_term = (cnt >= term);

  // divide the count events
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 8'h00;
    end else if (lnk.ps_clear) begin
      cnt <= 8'h00;
    end else if (lnk.tick_in) begin
      cnt <= at_term ? 8'h00 : cnt + 8'h01;
    end
  end

  assign lnk.tick_out = lnk.tick_in & at_term & ~lnk.ps_clear;
endmodule

// File: rtl/spt_timer.sv
/*
  sixteen-bit period timer/counter with an AXI4-Lite register slave,
  prescaler, gate accumulation, idle and sleep handling and one interrupt.
  assumes a single 100 MHz clock; cpu_idle and cpu_sleep come from logic on
  that clock; the external pin is asynchronous and is synchronised here.
*/
// Local design decisions: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps

module spt_timer (
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  // write address channel
  input  wire logic [spt_pkg::ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic [2:0]                     s_axi_awprot,
  input  wire logic                           s_axi_awvalid,
  output wire logic                           s_axi_awready,
  // write data channel
  input  wire logic [spt_pkg::DATA_W-1:0]     s_axi_wdata,
  input  wire logic [3:0]                     s_axi_wstrb,
  input  wire logic                           s_axi_wvalid,
  output wire logic                           s_axi_wready,
  // write response channel
  output logic      [1:0]                     s_axi_bresp,
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  // read address channel
  input  wire logic [spt_pkg::ADDR_W-1:0]     s_axi_araddr,
  input  wire logic [2:0]                     s_axi_arprot,
  input  wire logic                           s_axi_arvalid,
  output wire logic                           s_axi_arready,
  // read data channel
  output logic      [spt_pkg::DATA_W-1:0]     s_axi_rdata,
  output logic      [1:0]                     s_axi_rresp,
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  // device side
  input  wire logic                           timer_external_clock_pin,
  input  wire logic                           cpu_idle,
  input  wire logic                           cpu_sleep,
  output wire logic                           irq
);
  import spt_pkg::*;

  spt_link_if lnk ();                          // carrier to the helpers

  // registers
  logic [15:0]       count_value;              // running count
  logic [15:0]       period_value;             // match value
  logic [15:0]       timer_control_register;   // control bits
  logic [EV_N-1:0]   ev_status;                // sticky events
  logic [EV_N-1:0]   ev_enable;                // interrupt enables

  // write path holding registers
  logic              aw_hold;                  // write address taken
  logic              w_hold;                   // write data taken
  logic [ADDR_W-1:0] aw_addr;                  // held write address
  logic [15:0]       w_data;                   // held write data, low half
  logic [1:0]        w_strb;                   // held low byte lanes

  // control fields
  wire       timer_on_bit           = timer_control_register[BIT_ON];
  wire       idle_stop_bit          = timer_control_register[BIT_IDLE];
  wire       gate_accumulate_enable = timer_control_register[BIT_GATE];
  wire       external_sync_select   = timer_control_register[BIT_SYNC];
  wire       clock_source_select    = timer_control_register[BIT_CS];
  wire [1:0] prescale_select        = timer_control_register[BIT_PS_HI:BIT_PS_LO];

  // merge the enabled byte lanes of a write into a register
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [1:0]  strb);
    logic [15:0] r;
    r = old_v;
    if (strb[0]) begin
      r[7:0] = new_v[7:0];
    end
    if (strb[1]) begin
      r[15:8] = new_v[15:8];
    end
    return r;
  endfunction

  // ---- bus write side
  // address and data may come in either order; each half is held until
  // both are present, and neither ready returns before the answer is
  // taken, so at most one write is ever in flight
  assign s_axi_awready = ~aw_hold & ~s_axi_bvalid;   // one write at a time
  assign s_axi_wready  = ~w_hold & ~s_axi_bvalid;
  wire aw_fire  = s_axi_awvalid & s_axi_awready;
  wire w_fire   = s_axi_wvalid & s_axi_wready;
  wire wr_fire  = aw_hold & w_hold & ~s_axi_bvalid;  // both halves present

  // write decode
  wire wr_count  = wr_fire & (aw_addr == ADDR_COUNT);
  wire wr_period = wr_fire & (aw_addr == ADDR_PERIOD);
  wire wr_ctrl   = wr_fire & (aw_addr == ADDR_CTRL);
  wire wr_clear  = wr_fire & (aw_addr == ADDR_CLEAR);
  wire wr_enable = wr_fire & (aw_addr == ADDR_ENABLE);
  wire wr_hit    = wr_count | wr_period | wr_ctrl | wr_clear | wr_enable;

  // next values of written registers
  // unimplemented control bits are masked so they always read as zero
  wire [15:0] next_ctrl   = merge16(timer_control_register, w_data, w_strb) & CTRL_MASK;
  wire [15:0] next_wcount = merge16(count_value, w_data, w_strb);
  wire [15:0] clr_bits    = merge16(16'h0000, w_data, w_strb);
  wire [15:0] next_en     = merge16({14'h0000, ev_enable}, w_data, w_strb);

  // capture address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      aw_addr <= '0;
      w_data  <= 16'h0000;
      w_strb  <= 2'h0;
    end else begin
      if (aw_fire) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_hold <= 1'b0;
      end
      if (w_fire) begin
        w_hold  <= 1'b1;
        w_data  <= s_axi_wdata[15:0];
        w_strb  <= s_axi_wstrb[1:0];
      end else if (wr_fire) begin
        w_hold  <= 1'b0;
      end
    end
  end

  // write response, error for unmapped addresses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---- bus read side
  // the answer is registered from the address of the taking edge; arready
  // stays low until rready takes it, so reads never overlap
  assign s_axi_arready = ~s_axi_rvalid;               // one read at a time
  wire ar_fire = s_axi_arvalid & s_axi_arready;

  // read decode
  logic [15:0] rd_val;    // selected register
  logic        rd_hit;    // address mapped
  always_comb begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      ADDR_COUNT:  rd_val = count_value;
      ADDR_PERIOD: rd_val = period_value;
      ADDR_CTRL:   rd_val = timer_control_register;
      ADDR_STATUS: rd_val = {14'h0000, ev_status};
      ADDR_ENABLE: rd_val = {14'h0000, ev_enable};
      ADDR_CLEAR:  rd_val = 16'h0000;                 // write only
      default: begin
        rd_val = 16'h0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // read data from flops, held until taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {16'h0000, rd_val};
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---- count source and run conditions
  // sync and async counting both use the filtered pin rise; the two modes
  // differ only in whether sleep stops them
  wire gated_mode  = gate_accumulate_enable & ~clock_source_select;
  wire async_ext   = clock_source_select & ~external_sync_select;
  // idle halts every mode only when the idle stop bit is set
  wire idle_halt   = cpu_idle & idle_stop_bit;
  // sleep keeps only an enabled asynchronous external count
  wire sleep_halt  = cpu_sleep & ~async_ext;
  wire run         = timer_on_bit & ~idle_halt & ~sleep_halt;

  // source event before the prescaler
  logic src_event;
  always_comb begin
    if (clock_source_select) begin
      src_event = lnk.pin_rise;
    end else if (gate_accumulate_enable) begin
      src_event = lnk.pin_level;
    end else begin
      src_event = 1'b1;
    end
  end

  // prescaler only clocks while the timer runs
  assign lnk.tick_in  = run & src_event;
  assign lnk.ps_sel   = spt_ps_e'(prescale_select);
  // clear on a count write or on a write that drops the on bit
  assign lnk.ps_clear = wr_count |
                        (wr_ctrl & timer_on_bit & ~next_ctrl[BIT_ON]);

  // ---- count and match
  // a count write beats a step in the same cycle, so software never sees
  // its written value moved by one before it lands
  wire at_match   = (count_value == period_value);
  wire cnt_step   = lnk.tick_out & ~wr_count;
  wire match_ev   = cnt_step & at_match;
  wire gate_ev    = timer_on_bit & gated_mode & lnk.pin_fall;
  wire [EV_N-1:0] ev_set = {gate_ev, match_ev};

  // count register: written by software, stepped by the prescaler
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_value <= RST_COUNT;
    end else if (wr_count) begin
      count_value <= next_wcount;
    end else if (cnt_step) begin
      count_value <= at_match ? 16'h0000 : count_value + 16'h0001;
    end
  end

  // period and control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_value           <= RST_PERIOD;
      timer_control_register <= RST_CTRL;
    end else begin
      if (wr_period) begin
        period_value <= merge16(period_value, w_data, w_strb);
      end
      if (wr_ctrl) begin
        timer_control_register <= next_ctrl;
      end
    end
  end

  // sticky status: set wins over clear, only software clears
  // an event in the cycle of its own clear stays pending, so no match
  // or gate fall is ever lost to a badly timed clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev_status <= RST_EV;
      ev_enable <= RST_EV;
    end else begin
      ev_status <= (ev_status & ~(wr_clear ? clr_bits[EV_N-1:0] : RST_EV))
                   | ev_set;
      if (wr_enable) begin
        ev_enable <= next_en[EV_N-1:0];
      end
    end
  end

  // level interrupt while any enabled event is pending
  // built from flops only, so it cannot glitch on bus inputs
  assign irq = |(ev_status & ev_enable);

  // ---- helpers
  // the pin passes three flops before any logic here reads it
  spt_pin_sync spt_pin_sync_i (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_raw (timer_external_clock_pin),
    .lnk     (lnk.sync)
  );

  spt_prescaler spt_prescaler_i (
    .aclk    (aclk),
    .aresetn (aresetn),
    .lnk     (lnk.pre)
  );

endmodule

// File: test/spt_timer_chk.sv
/*
  checker for the timer's bus answers and interrupt output.
  assumes it is bound onto the spt_timer ports.
*/
`timescale 1ns/10ps
module spt_timer_chk (
  input wire logic                       aclk,
  input wire logic                       aresetn,
  input wire logic                       s_axi_awvalid,
  input wire logic                       s_axi_awready,
  input wire logic                       s_axi_wvalid,
  input wire logic                       s_axi_wready,
  input wire logic [1:0]                 s_axi_bresp,
  input wire logic                       s_axi_bvalid,
  input wire logic                       s_axi_bready,
  input wire logic                       s_axi_arvalid,
  input wire logic                       s_axi_arready,
  input wire logic [spt_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0]                 s_axi_rresp,
  input wire logic                       s_axi_rvalid,
  input wire logic                       s_axi_rready,
  input wire logic                       irq
);
  import spt_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // answers stand until taken
  chk_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  chk_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read answer dropped");
  // no new request while an answer waits
  chk_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during answer");
  chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during answer");
  // sixteen-bit registers in the low half
  chk_r_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  // answer latencies
  chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_w_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
  chk_b_legal: assert property (s_axi_bvalid |->
    s_axi_bresp == RESP_OKAY || s_axi_bresp == RESP_SLVERR) else $error("bad bresp");
  chk_reset_quiet: assert property ($rose(aresetn) |->
    !s_axi_bvalid && !s_axi_rvalid && !irq) else $error("busy out of reset");
  // flag falls only through a bus write
  chk_irq_clear: assert property ($fell(irq) |-> s_axi_bvalid)
    else $error("irq cleared by itself");
  cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  cover property ($rose(irq));
  cover property ($fell(irq));
endmodule

bind spt_timer spt_timer_chk spt_timer_chk_i (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .irq(irq));

// File: test/spt_pin_src.sv
/*
  external clock or gate source for the timer pin.
  assumes the pin is sampled on aclk; idles low between bursts.
*/
`timescale 1ns/10ps
module spt_pin_src (
  input wire logic aclk,
  output logic     timer_external_clock_pin
);
  initial timer_external_clock_pin = 1'b0;
  // each pulse high three cycles, low three cycles
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge aclk);
      timer_external_clock_pin <= 1'b1;
      repeat (3) @(posedge aclk);
      timer_external_clock_pin <= 1'b0;
      repeat (2) @(posedge aclk);
    end
  endtask
endmodule

// File: test/spt_timer_tb.sv
/*
  self-checking bench for spt_timer: bus master, pin source, note queues.
  assumes the checker is bound and the pin source model is compiled.
*/
`timescale 1ns/10ps
module spt_timer_tb;
  import spt_pkg::*;
  localparam logic [15:0] ON = 16'h8000, IDL = 16'h2000, GT = 16'h0040;
  localparam logic [15:0] SY = 16'h0004, CS = 16'h0002;
  logic              aclk = 0, aresetn = 0, idle = 0, sleep = 0;
  logic [ADDR_W-1:0] awaddr = 0, araddr = 0;
  logic              awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic [DATA_W-1:0] wdata = 0;
  logic [2:0]        awprot = 0, arprot = 0;
  logic [3:0]        wstrb = 0;
  wire logic         awr, wrd, bv, arr, rv, irq, pin;
  wire logic [1:0]   bresp, rresp;
  wire logic [31:0]  rdata;
  int                bad_count = 0, n_tests = 0, p, n;
  int                dv[4] = '{1, 8, 64, 256};
  logic [33:0]       rq[$];   // expected read answers
  logic [1:0]        bq[$];   // expected write answers
  always #5 aclk = ~aclk;
  spt_timer spt_timer_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(awprot), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(arprot),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rready), .timer_external_clock_pin(pin),
    .cpu_idle(idle), .cpu_sleep(sleep), .irq(irq));
  spt_pin_src spt_pin_src_i (.aclk(aclk), .timer_external_clock_pin(pin));
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("tests=%0d mismatches=%0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // watcher: oldest note against each answer
  always @(posedge aclk) begin
    if (rv && rready) check({rresp, rdata}, rq.pop_front());
    if (bv && bready) check(34'(bresp), 34'(bq.pop_front()));
  end
  task automatic wr(input logic [11:0] a, input logic [15:0] d,
                    input logic [1:0] r = RESP_OKAY, input logic [1:0] ln = 2'h3);
    logic ta, td;
    ta = 0;
    td = 0;
    bq.push_back(r);
    @(posedge aclk);
    awaddr <= a; wdata <= {16'($urandom), d}; awv <= 1; wv <= 1; bready <= 1;
    awprot <= 3'($urandom); wstrb <= {2'($urandom), ln};
    while (!(ta && td)) begin
      @(posedge aclk);
      if (!ta && awr) begin ta = 1; awv <= 0; end
      if (!td && wrd) begin td = 1; wv <= 0; end
    end
    do @(posedge aclk); while (!bv);
    bready <= 0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [15:0] d,
                    input logic [1:0] r = RESP_OKAY);
    rq.push_back({r, 16'h0000, d});
    @(posedge aclk);
    araddr <= a; arv <= 1; rready <= 1;
    arprot <= 3'($urandom);
    do @(posedge aclk); while (!arr);
    arv <= 0;
    do @(posedge aclk); while (!rv);
    rready <= 0;
  endtask
  // stop, zero the count, set control, send pulses, let them settle
  task automatic cnt(input int k, input logic [15:0] ctl);
    wr(ADDR_CTRL, 16'h0000);
    wr(ADDR_COUNT, 16'h0000);
    wr(ADDR_CTRL, ctl);
    spt_pin_src_i.pulses(k);
    repeat (20) @(posedge aclk);
  endtask
  initial begin
    #600000;
    bad_count++;
    close_out;
  end
  initial begin
    void'($urandom(32'h27ae1c6d));
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    // reset values, unmapped and read-only places
    rd(ADDR_COUNT, RST_COUNT); rd(ADDR_PERIOD, RST_PERIOD); rd(ADDR_CTRL, RST_CTRL);
    rd(ADDR_STATUS, 16'h0000); rd(ADDR_ENABLE, 16'h0000); rd(ADDR_CLEAR, 16'h0000);
    rd(12'h7FC, 16'h0000, RESP_SLVERR);
    wr(12'h7FC, 16'hFFFF, RESP_SLVERR);
    wr(ADDR_STATUS, 16'h0003, RESP_SLVERR);
    rd(ADDR_STATUS, 16'h0000);
    // byte lanes: one lane at a time into the period
    wr(ADDR_PERIOD, 16'h1200, RESP_OKAY, 2'h1);
    rd(ADDR_PERIOD, 16'hFF00);
    wr(ADDR_PERIOD, 16'h1200, RESP_OKAY, 2'h2);
    rd(ADDR_PERIOD, 16'h1200);
    wr(ADDR_COUNT, 16'h1234);
    wr(ADDR_CTRL, 16'h0030);
    rd(ADDR_COUNT, 16'h1234);
    // every prescale code: 3*ratio-1 pulses give two steps
    for (int i = 0; i < 4; i++) begin
      cnt(3 * dv[i] - 1, ON | CS | SY | 16'(i << 4));
      rd(ADDR_COUNT, 16'h0002);
    end
    // wrap in sync and async counting
    p = 2 + $urandom % 6;
    n = p + 2 + $urandom % 4;
    wr(ADDR_PERIOD, 16'(p));
    for (int s = 0; s < 2; s++) begin
      wr(ADDR_CLEAR, 16'h0003);
      cnt(n, ON | CS | (s == 0 ? SY : 16'h0000));
      rd(ADDR_COUNT, 16'(n % (p + 1)));
      rd(ADDR_STATUS, 16'h0001);
    end
    #1 check(34'(irq), 34'h0);
    wr(ADDR_ENABLE, 16'h0001);
    #1 check(34'(irq), 34'h1);
    wr(ADDR_CLEAR, 16'h0001);
    #1 check(34'(irq), 34'h0);
    // sleep: only enabled async external counting survives
    @(posedge aclk) sleep <= 1;
    cnt(4, ON | CS | SY);
    rd(ADDR_COUNT, 16'h0000);
    cnt(0, ON);
    rd(ADDR_COUNT, 16'h0000);
    cnt(n, ON | CS);
    rd(ADDR_COUNT, 16'(n % (p + 1)));
    #1 check(34'(irq), 34'h1);
    @(posedge aclk) sleep <= 0;
    wr(ADDR_CLEAR, 16'h0003);
    // idle with and without the stop bit
    @(posedge aclk) idle <= 1;
    cnt(4, ON | CS | IDL);
    rd(ADDR_COUNT, 16'h0000);
    cnt(4, ON | CS);
    rd(ADDR_COUNT, 16'(4 % (p + 1)));
    cnt(0, ON | IDL);
    rd(ADDR_COUNT, 16'h0000);
    wr(ADDR_CLEAR, 16'h0003);
    @(posedge aclk) idle <= 0;
    repeat (40) @(posedge aclk);
    rd(ADDR_STATUS, 16'h0001);
    // prescaler clear by count write and by on-bit clear
    wr(ADDR_PERIOD, 16'hFFFF);
    cnt(5, ON | CS | SY | 16'h0010);
    wr(ADDR_COUNT, 16'h0000);
    spt_pin_src_i.pulses(4);
    repeat (20) @(posedge aclk);
    rd(ADDR_COUNT, 16'h0000);
    wr(ADDR_CTRL, CS | SY | 16'h0010);
    wr(ADDR_CTRL, ON | CS | SY | 16'h0010);
    spt_pin_src_i.pulses(4);
    repeat (20) @(posedge aclk);
    rd(ADDR_COUNT, 16'h0000);
    spt_pin_src_i.pulses(4);
    repeat (20) @(posedge aclk);
    rd(ADDR_COUNT, 16'h0001);
    // gate: pin low holds the count, its fall flags
    wr(ADDR_CLEAR, 16'h0003);
    cnt(0, ON | GT);
    rd(ADDR_COUNT, 16'h0000);
    spt_pin_src_i.pulses(1);
    repeat (20) @(posedge aclk);
    rd(ADDR_COUNT, 16'h0003);
    rd(ADDR_STATUS, 16'h0002);
    close_out;
  end
endmodule
